// ---- rtl/flag_cfg_params.svh ----
`ifndef FLAG_CFG_PARAMS_SVH
`define FLAG_CFG_PARAMS_SVH

// ****************************************
// Command register offsets
// ****************************************
`define CMD_ADDR_W 6
`define REG_IFC 6'h01
`define REG_FLAG_AB 6'h02
`define REG_FLAG_CD 6'h03
`define REG_POL 6'h04
`define REG_PTR_LO 6'h3a
`define REG_PTR_HI 6'h3b
`define REG_HDATA 6'h3c
`define HIDDEN_POL_ADDR 16'he609

// ****************************************
// Reset values and write masks
// ****************************************
`define IFC_RESET 8'hc9
`define FLAG_SEL_RESET 8'h00
`define POL_RESET 8'h00
`define PTR_RESET 8'h00
`define POL_SW_MASK 8'ha3
`define POL_HIDDEN_MASK 8'hbf

// ****************************************
// Field positions
// ****************************************
`define IFC_STROBE_MODE_SELECT 3
`define IFC_STANDBY 2
`define IFC_SHARED 1
`define IFC_DETACH 0
`define POL_WAKE 7
`define POL_PKT 5
`define POL_OE 4
`define POL_RD 3
`define POL_WR 2
`define POL_EMPTY 1
`define POL_FULL 0
`define FIFO_IDX_HI 1
`define FIFO_IDX_LO 0

// ****************************************
// Flag select coding
// ****************************************
`define FSEL_FIXED 4'h0
`define FSEL_GRP_FIXED 2'b00
`define FSEL_GRP_PROG 2'b01
`define FSEL_GRP_EMPTY 2'b10
`define FSEL_GRP_FULL 2'b11
`define FLAG_INACTIVE 1'b0

`endif

// ---- rtl/flag_cfg_pkg.sv ----
`default_nettype none
package flag_cfg_pkg;
  typedef logic [3:0] flag_sel_t;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    NIB_HI = 2'b01,
    NIB_LO = 2'b10
  } nib_state_e;
endpackage
`default_nettype wire

// ---- rtl/flag_route_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface flag_route_if #(parameter int NUM_EP = 4);
  import flag_cfg_pkg::*;
  flag_sel_t sel [4];
  logic [NUM_EP-1:0] prog;
  logic [NUM_EP-1:0] empty;
  logic [NUM_EP-1:0] full;
  logic [1:0] addr_idx;
  logic empty_hi;
  logic full_hi;
  logic [3:0] level;
  modport cfg (output sel, prog, empty, full, addr_idx, empty_hi, full_hi, input level);
  modport route (input sel, prog, empty, full, addr_idx, empty_hi, full_hi, output level);
endinterface
`default_nettype wire

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Pins
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      // A change is taken once the second and third stages agree
      always_comb
      begin
        lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      end
      always_ff @(posedge i_core_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= i_pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          lvl_q[g] <= lvl_d[g];
        end
      end
    end
  endgenerate

  assign o_level = lvl_q;
endmodule
`default_nettype wire

// ---- rtl/flag_router.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flag_cfg_params.svh"
module flag_router (
  flag_route_if.route rt
);
  import flag_cfg_pkg::*;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_flag
      logic [1:0] ep;
      logic e_lvl;
      logic f_lvl;
      always_comb
      begin
        ep = rt.sel[g][1:0];
        e_lvl = rt.empty_hi ? rt.empty[ep] : ~rt.empty[ep];
        f_lvl = rt.full_hi ? rt.full[ep] : ~rt.full[ep];
        rt.level[g] = `FLAG_INACTIVE;
        unique case (rt.sel[g][3:2])
          `FSEL_GRP_FIXED:
          begin
            // Code zero follows the addressed FIFO on flags A-C only; other codes here are reserved
            if (rt.sel[g] == `FSEL_FIXED)
            begin
              if (g == 0)
                rt.level[g] = rt.prog[rt.addr_idx];
              else if (g == 1)
                rt.level[g] = rt.full_hi ? rt.full[rt.addr_idx] : ~rt.full[rt.addr_idx];
              else if (g == 2)
                rt.level[g] = rt.empty_hi ? rt.empty[rt.addr_idx] : ~rt.empty[rt.addr_idx];
            end
          end
          `FSEL_GRP_PROG: rt.level[g] = rt.prog[ep];
          `FSEL_GRP_EMPTY: rt.level[g] = e_lvl;
          `FSEL_GRP_FULL: rt.level[g] = f_lvl;
        endcase
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/fifo_flag_polarity_config.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flag_cfg_params.svh"
// Functional notes
// - Asynchronous mode, the reset default, takes read and write pins as direct strobes.
// - Synchronous mode samples read and write as enables on interface clock edges.
// - Writing standby bit 2 to one stops the oscillator.
// - Standby ends on resumed bus activity or an active wakeup pin.
// - Shared pin bit 1: zero is chip select, one is fourth flag output.
// - Detach bit 0: one floats the D+ pull-up, zero enables it.
// - Four 4-bit select fields in registers 0x02 and 0x03, reset zero.
// - Code zero gives fixed flags A-C for the FIFO addressed by the pins; flag D stays inactive.
// - Codes 1-3 reserved; 4-7 programmable, 8-11 empty, 12-15 full, per endpoint.
// - Codes 4-15 route each flag independently of the FIFO address pins.
// - Wake polarity bit 7: zero active low, one active high.
// - Packet-end polarity bit 5: zero active low, one active high.
// - Strobe polarity bits 4..2 read-only at 0x04, active low after reset.
// - Empty polarity bit 1 chooses the empty flag level.
// - Full polarity bit 0 chooses the full flag level.
// - Hidden polarity register at 0xE609, strobe polarity bits writable there.
module fifo_flag_polarity_config
#(
  parameter int NUM_EP = 4
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Command port
  input wire logic i_cmd_valid,
  input wire logic i_cmd_addr_phase,
  input wire logic i_cmd_read,
  input wire flag_cfg_pkg::reg_byte_t i_cmd_byte,
  output flag_cfg_pkg::reg_byte_t o_rd_data,
  output logic o_rd_valid,
  // Interface pins
  input wire logic [2:0] i_fifo_select_inputs,
  input wire logic i_read_strobe_input,
  input wire logic i_write_strobe_input,
  input wire logic i_output_enable_input,
  input wire logic i_packet_end_input,
  input wire logic i_wake_pin,
  input wire logic i_interface_clock_pin,
  // Endpoint FIFO state
  input wire logic i_bus_activity,
  input wire logic [NUM_EP-1:0] i_ep_programmable_flag,
  input wire logic [NUM_EP-1:0] i_ep_empty_flag,
  input wire logic [NUM_EP-1:0] i_ep_full_flag,
  // Flag pins
  output logic o_flag_out_a,
  output logic o_flag_out_b,
  output logic o_flag_out_c,
  output logic o_flag_out_d,
  output logic o_flag_out_d_oe,
  // Decoded strobes
  output logic o_read_pulse,
  output logic o_write_pulse,
  output logic o_output_enable,
  output logic o_packet_end,
  // Interface state
  output logic o_strobe_mode_select,
  output logic o_osc_stop,
  output logic o_pullup_en
);
  import flag_cfg_pkg::*;
  generate
    if (NUM_EP != 4)
    begin : g_check
      $error("NUM_EP must be 4");
    end
  endgenerate

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_lvl;
  logic [2:0] fsel;
  logic rd_pin;
  logic wr_pin;
  logic oe_pin;
  logic pkt_pin;
  logic wake_pin;
  logic interface_clock_pin_pin;

  pin_sync #(.W(NPIN)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_pin({i_interface_clock_pin, i_wake_pin, i_packet_end_input, i_output_enable_input,
            i_write_strobe_input, i_read_strobe_input, i_fifo_select_inputs}),
    .o_level(pin_lvl)
  );
  assign {interface_clock_pin_pin, wake_pin, pkt_pin, oe_pin, wr_pin, rd_pin, fsel} = pin_lvl;

  // ****************************************
  // Command registers
  // ****************************************
  nib_state_e nib_q;
  nib_state_e nib_d;
  logic [`CMD_ADDR_W-1:0] addr_q;
  logic [`CMD_ADDR_W-1:0] addr_d;
  logic [3:0] hi_nib_q;
  logic [3:0] hi_nib_d;
  reg_byte_t ifc_q;
  reg_byte_t ifc_d;
  reg_byte_t sel_ab_q;
  reg_byte_t sel_ab_d;
  reg_byte_t sel_cd_q;
  reg_byte_t sel_cd_d;
  reg_byte_t pol_q;
  reg_byte_t pol_d;
  reg_byte_t ptr_lo_q;
  reg_byte_t ptr_lo_d;
  reg_byte_t ptr_hi_q;
  reg_byte_t ptr_hi_d;
  reg_byte_t rd_data_q;
  reg_byte_t rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic wr_fire;
  reg_byte_t wr_byte;
  logic wake_evt;
  logic wake_act;

  assign wake_act = pol_q[`POL_WAKE] ? wake_pin : ~wake_pin;
  assign wake_evt = ifc_q[`IFC_STANDBY] & (i_bus_activity | wake_act);

  always_comb
  begin
    nib_d = nib_q;
    addr_d = addr_q;
    hi_nib_d = hi_nib_q;
    ifc_d = ifc_q;
    sel_ab_d = sel_ab_q;
    sel_cd_d = sel_cd_q;
    pol_d = pol_q;
    ptr_lo_d = ptr_lo_q;
    ptr_hi_d = ptr_hi_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    wr_fire = 1'b0;
    wr_byte = {hi_nib_q, i_cmd_byte[3:0]};
    // Each byte arrives as upper nibble then lower nibble
    if (i_cmd_valid && i_cmd_addr_phase)
    begin
      addr_d = i_cmd_byte[`CMD_ADDR_W-1:0];
      nib_d = NIB_HI;
    end
    else if (i_cmd_valid)
    begin
      unique case (nib_q)
        NIB_HI:
        begin
          hi_nib_d = i_cmd_byte[3:0];
          nib_d = NIB_LO;
        end
        NIB_LO:
        begin
          wr_fire = 1'b1;
          nib_d = NIB_HI;
        end
      endcase
    end
    // Wakeup clears standby; a write in the same cycle takes priority
    if (wake_evt)
      ifc_d[`IFC_STANDBY] = 1'b0;
    if (wr_fire)
    begin
      case (addr_q)
        `REG_IFC: ifc_d = wr_byte;
        `REG_FLAG_AB: sel_ab_d = wr_byte;
        `REG_FLAG_CD: sel_cd_d = wr_byte;
        `REG_POL: pol_d = (pol_q & ~`POL_SW_MASK) | (wr_byte & `POL_SW_MASK);
        `REG_PTR_LO: ptr_lo_d = wr_byte;
        `REG_PTR_HI: ptr_hi_d = wr_byte;
        `REG_HDATA:
        begin
          if ({ptr_hi_q, ptr_lo_q} == `HIDDEN_POL_ADDR)
            pol_d = wr_byte & `POL_HIDDEN_MASK;
        end
        default:
        begin
        end
      endcase
    end
    if (i_cmd_read)
    begin
      rd_valid_d = 1'b1;
      case (addr_q)
        `REG_IFC: rd_data_d = ifc_q;
        `REG_FLAG_AB: rd_data_d = sel_ab_q;
        `REG_FLAG_CD: rd_data_d = sel_cd_q;
        `REG_POL: rd_data_d = pol_q;
        `REG_PTR_LO: rd_data_d = ptr_lo_q;
        `REG_PTR_HI: rd_data_d = ptr_hi_q;
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      nib_q <= NIB_HI;
      addr_q <= '0;
      hi_nib_q <= 4'h0;
      ifc_q <= `IFC_RESET;
      sel_ab_q <= `FLAG_SEL_RESET;
      sel_cd_q <= `FLAG_SEL_RESET;
      pol_q <= `POL_RESET;
      ptr_lo_q <= `PTR_RESET;
      ptr_hi_q <= `PTR_RESET;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      nib_q <= nib_d;
      addr_q <= addr_d;
      hi_nib_q <= hi_nib_d;
      ifc_q <= ifc_d;
      sel_ab_q <= sel_ab_d;
      sel_cd_q <= sel_cd_d;
      pol_q <= pol_d;
      ptr_lo_q <= ptr_lo_d;
      ptr_hi_q <= ptr_hi_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // ****************************************
  // Flag routing
  // ****************************************
  flag_route_if #(.NUM_EP(NUM_EP)) frt ();

  assign frt.sel[0] = sel_ab_q[3:0];
  assign frt.sel[1] = sel_ab_q[7:4];
  assign frt.sel[2] = sel_cd_q[3:0];
  assign frt.sel[3] = sel_cd_q[7:4];
  assign frt.prog = i_ep_programmable_flag;
  assign frt.empty = i_ep_empty_flag;
  assign frt.full = i_ep_full_flag;
  assign frt.addr_idx = fsel[`FIFO_IDX_HI:`FIFO_IDX_LO];
  assign frt.empty_hi = pol_q[`POL_EMPTY];
  assign frt.full_hi = pol_q[`POL_FULL];

  flag_router u_router (
    .rt(frt.route)
  );

  // ****************************************
  // Strobe decode and pin outputs
  // ****************************************
  logic rd_act;
  logic wr_act;
  logic rd_prev_q;
  logic wr_prev_q;
  logic interface_clock_pin_prev_q;
  logic interface_clock_pin_rise;
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  logic rd_pulse_q;
  logic rd_pulse_d;
  logic wr_pulse_q;
  logic wr_pulse_d;
  logic oe_q;
  logic oe_d;
  logic pkt_q;
  logic pkt_d;
  logic pullup_q;
  logic pullup_d;

  assign rd_act = pol_q[`POL_RD] ? rd_pin : ~rd_pin;
  assign wr_act = pol_q[`POL_WR] ? wr_pin : ~wr_pin;
  assign interface_clock_pin_rise = interface_clock_pin_pin & ~interface_clock_pin_prev_q;

  always_comb
  begin
    flag_d = frt.level;
    // Next shared bit, so the pin never shows a flag once its enable has dropped
    if (!ifc_d[`IFC_SHARED])
      flag_d[3] = `FLAG_INACTIVE;
    if (ifc_q[`IFC_STROBE_MODE_SELECT])
    begin
      rd_pulse_d = rd_act & ~rd_prev_q;
      wr_pulse_d = wr_act & ~wr_prev_q;
    end
    else
    begin
      rd_pulse_d = rd_act & interface_clock_pin_rise;
      wr_pulse_d = wr_act & interface_clock_pin_rise;
    end
    oe_d = pol_q[`POL_OE] ? oe_pin : ~oe_pin;
    pkt_d = pol_q[`POL_PKT] ? pkt_pin : ~pkt_pin;
    pullup_d = ~ifc_q[`IFC_DETACH];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      interface_clock_pin_prev_q <= 1'b1;
      flag_q <= 4'h0;
      rd_pulse_q <= 1'b0;
      wr_pulse_q <= 1'b0;
      oe_q <= 1'b0;
      pkt_q <= 1'b0;
      pullup_q <= 1'b0;
    end
    else
    begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
      interface_clock_pin_prev_q <= interface_clock_pin_pin;
      flag_q <= flag_d;
      rd_pulse_q <= rd_pulse_d;
      wr_pulse_q <= wr_pulse_d;
      oe_q <= oe_d;
      pkt_q <= pkt_d;
      pullup_q <= pullup_d;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_flag_out_a = flag_q[0];
  assign o_flag_out_b = flag_q[1];
  assign o_flag_out_c = flag_q[2];
  assign o_flag_out_d = flag_q[3];
  assign o_flag_out_d_oe = ifc_q[`IFC_SHARED];
  assign o_read_pulse = rd_pulse_q;
  assign o_write_pulse = wr_pulse_q;
  assign o_output_enable = oe_q;
  assign o_packet_end = pkt_q;
  assign o_strobe_mode_select = ifc_q[`IFC_STROBE_MODE_SELECT];
  assign o_osc_stop = ifc_q[`IFC_STANDBY];
  assign o_pullup_en = pullup_q;
endmodule
`default_nettype wire

// ---- sim/flag_cfg_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module flag_cfg_monitor (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Inputs
  input wire logic i_cmd_valid,
  input wire logic i_cmd_read,
  input wire logic i_bus_activity,
  // Outputs
  input wire flag_cfg_pkg::reg_byte_t o_rd_data,
  input wire logic o_rd_valid,
  input wire logic o_flag_out_d,
  input wire logic o_flag_out_d_oe,
  input wire logic o_read_pulse,
  input wire logic o_write_pulse,
  input wire logic o_strobe_mode_select,
  input wire logic o_osc_stop,
  input wire logic o_pullup_en
);
  // ****
  // Port checks
  // ****
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_read_answer_due: assert property (i_cmd_read |=> o_rd_valid)
    else $error("read answer missing");
  a_no_stray_answer: assert property (!i_cmd_read |=> !o_rd_valid)
    else $error("read answer without read");
  a_read_data_holds: assert property (!i_cmd_read |=> $stable(o_rd_data))
    else $error("read data moved without read");
  a_standby_by_write: assert property ($rose(o_osc_stop) |-> $past(i_cmd_valid))
    else $error("standby entered without write");
  a_wake_on_bus: assert property (o_osc_stop && i_bus_activity && !i_cmd_valid |-> ##[1:2] !o_osc_stop)
    else $error("bus activity did not wake");
  a_shared_pin_idle: assert property (!o_flag_out_d_oe |-> !o_flag_out_d)
    else $error("flag d driven as chip select");
  a_strobe_mode_select_read_pulse: assert property (o_strobe_mode_select && o_read_pulse |=> !o_read_pulse)
    else $error("strobe_mode_select read pulse too long");
  a_strobe_mode_select_write_pulse: assert property (o_strobe_mode_select && o_write_pulse |=> !o_write_pulse)
    else $error("strobe_mode_select write pulse too long");
  a_pullup_by_write: assert property ($changed(o_pullup_en) |-> $past(i_cmd_valid, 2))
    else $error("pull-up changed without write");
endmodule
bind fifo_flag_polarity_config flag_cfg_monitor i_flag_cfg_monitor (.i_core_clk, .i_rst_b,
  .i_cmd_valid, .i_cmd_read, .i_bus_activity, .o_rd_data, .o_rd_valid, .o_flag_out_d,
  .o_flag_out_d_oe, .o_read_pulse, .o_write_pulse, .o_strobe_mode_select, .o_osc_stop,
  .o_pullup_en);
`default_nettype wire

// ---- sim/ext_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_master (
  // Clock
  input wire logic i_core_clk,
  // Command port
  input wire flag_cfg_pkg::reg_byte_t i_rd_data,
  output logic o_cmd_valid,
  output logic o_cmd_addr_phase,
  output logic o_cmd_read,
  output flag_cfg_pkg::reg_byte_t o_cmd_byte
);
  import flag_cfg_pkg::*;
  // ****
  // Command master
  // ****
  reg_byte_t exp_q[$];
  initial
  begin
    {o_cmd_valid, o_cmd_addr_phase, o_cmd_read} = 3'h0;
    o_cmd_byte = 8'h00;
  end
  task automatic put(input logic ap, input reg_byte_t b);
    @(negedge i_core_clk);
    {o_cmd_valid, o_cmd_addr_phase, o_cmd_read} = {1'b1, ap, 1'b0};
    o_cmd_byte = b;
  endtask
  // Released byte lines are scrambled so a stale value never looks valid
  task automatic idle();
    @(negedge i_core_clk);
    {o_cmd_valid, o_cmd_read} = 2'h0;
    o_cmd_byte = ~o_cmd_byte;
  endtask
  task automatic wr_reg(input reg_byte_t a, input reg_byte_t v);
    put(1'b1, a);
    put(1'b0, {4'h0, v[7:4]});
    put(1'b0, {4'h0, v[3:0]});
    idle();
  endtask
  task automatic wr_hidden(input logic [15:0] a, input reg_byte_t v);
    wr_reg(8'h3a, a[7:0]);
    wr_reg(8'h3b, a[15:8]);
    wr_reg(8'h3c, v);
  endtask
  task automatic rd_reg(input reg_byte_t a, input reg_byte_t e);
    put(1'b1, a);
    @(negedge i_core_clk);
    {o_cmd_valid, o_cmd_read} = 2'b01;
    exp_q.push_back(e);
    idle();
  endtask
  task automatic rmw_pol(input reg_byte_t clr, input reg_byte_t set, input reg_byte_t e);
    rd_reg(8'h04, e);
    wr_hidden(16'he609, (i_rd_data & ~clr) | set);
  endtask
endmodule
`default_nettype wire

// ---- sim/fifo_flag_polarity_config_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_flag_polarity_config_tb_top;
  import flag_cfg_pkg::*;
  // ****
  // Bench
  // ****
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_cmd_valid, i_cmd_addr_phase, i_cmd_read, o_rd_valid;
  reg_byte_t i_cmd_byte, o_rd_data, exp_rd;
  logic [2:0] i_fifo_select_inputs = 3'h0;
  logic i_read_strobe_input = 1'b1, i_write_strobe_input = 1'b1;
  logic i_output_enable_input = 1'b1, i_packet_end_input = 1'b1, i_wake_pin = 1'b1;
  logic i_interface_clock_pin = 1'b0, i_bus_activity = 1'b0;
  logic [3:0] i_ep_programmable_flag = 4'h0, i_ep_empty_flag = 4'h0, i_ep_full_flag = 4'h0;
  logic o_flag_out_a, o_flag_out_b, o_flag_out_c, o_flag_out_d, o_flag_out_d_oe;
  logic o_read_pulse, o_write_pulse, o_output_enable, o_packet_end;
  logic o_strobe_mode_select, o_osc_stop, o_pullup_en;
  logic [15:0] lfsr = 16'h8cb6;
  int err_count = 0, n_compared = 0, n_rd = 0, n_wr = 0;
  always #5 i_core_clk = ~i_core_clk;
  fifo_flag_polarity_config #(.NUM_EP(4)) i_fifo_flag_polarity_config (.i_core_clk, .i_rst_b,
    .i_cmd_valid, .i_cmd_addr_phase, .i_cmd_read, .i_cmd_byte, .o_rd_data, .o_rd_valid,
    .i_fifo_select_inputs, .i_read_strobe_input, .i_write_strobe_input, .i_output_enable_input,
    .i_packet_end_input, .i_wake_pin, .i_interface_clock_pin, .i_bus_activity,
    .i_ep_programmable_flag, .i_ep_empty_flag, .i_ep_full_flag, .o_flag_out_a, .o_flag_out_b,
    .o_flag_out_c, .o_flag_out_d, .o_flag_out_d_oe, .o_read_pulse, .o_write_pulse,
    .o_output_enable, .o_packet_end, .o_strobe_mode_select, .o_osc_stop, .o_pullup_en);
  ext_master i_ext_master (.i_core_clk, .i_rd_data(o_rd_data), .o_cmd_valid(i_cmd_valid),
    .o_cmd_addr_phase(i_cmd_addr_phase), .o_cmd_read(i_cmd_read), .o_cmd_byte(i_cmd_byte));
  task automatic chk(input string nm, input reg_byte_t e, input reg_byte_t g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // Code 0 meaning per pin: 0 programmable, 1 full, 2 empty, 3 none
  function automatic logic exp_flag(input logic [3:0] c, input int fx, input reg_byte_t p);
    logic [3:0] k;
    logic [1:0] e;
    k = c;
    e = c[1:0];
    if (c == 4'h0)
    begin
      k = (fx == 0) ? 4'h4 : (fx == 1) ? 4'hc : (fx == 2) ? 4'h8 : 4'h1;
      e = i_fifo_select_inputs[1:0];
    end
    case (k[3:2])
      2'b01: return i_ep_programmable_flag[e];
      2'b10: return p[1] ? i_ep_empty_flag[e] : !i_ep_empty_flag[e];
      2'b11: return p[0] ? i_ep_full_flag[e] : !i_ep_full_flag[e];
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic flag_pass(input reg_byte_t p);
    logic [3:0] c;
    i_ext_master.wr_reg(8'h04, p);
    for (int k = 0; k < 16; k++)
    begin
      c = k[3:0];
      i_ext_master.wr_reg(8'h02, {c, c});
      i_ext_master.wr_reg(8'h03, {c, c});
      repeat (2)
      begin
        lfsr = lfsr_next(lfsr);
        {i_ep_programmable_flag, i_ep_empty_flag, i_ep_full_flag} = lfsr[11:0];
        i_fifo_select_inputs = {1'b0, lfsr[15:14]};
        gap(8);
        chk("flag_a", exp_flag(c, 0, p), o_flag_out_a);
        chk("flag_b", exp_flag(c, 1, p), o_flag_out_b);
        chk("flag_c", exp_flag(c, 2, p), o_flag_out_c);
        chk("flag_d", exp_flag(c, 3, p), o_flag_out_d);
      end
    end
  endtask
  always @(negedge i_core_clk)
    if (o_rd_valid === 1'b1)
    begin
      exp_rd = i_ext_master.exp_q.pop_front();
      chk("rd_data", exp_rd, o_rd_data);
    end
  always @(negedge i_core_clk)
  begin
    if (o_read_pulse === 1'b1) n_rd++;
    if (o_write_pulse === 1'b1) n_wr++;
  end
  initial
  begin
    #500us;
    err_count++;
    finish_test();
  end
  initial
  begin
    gap(16);
    i_rst_b = 1'b1;
    chk("strobe_mode_select", 8'h01, o_strobe_mode_select);
    chk("pullup", 8'h00, o_pullup_en);
    chk("d_oe", 8'h00, o_flag_out_d_oe);
    i_ext_master.rd_reg(8'h01, 8'hc9);
    i_ext_master.rd_reg(8'h02, 8'h00);
    i_ext_master.rd_reg(8'h03, 8'h00);
    i_ext_master.rd_reg(8'h04, 8'h00);
    i_ext_master.rd_reg(8'h07, 8'h00);
    i_ext_master.wr_reg(8'h01, 8'hca);
    gap(2);
    chk("pullup", 8'h01, o_pullup_en);
    chk("d_oe", 8'h01, o_flag_out_d_oe);
    i_ext_master.wr_reg(8'h04, 8'hff);
    i_ext_master.rd_reg(8'h04, 8'ha3);
    flag_pass(8'h00);
    flag_pass(8'h03);
    // Flag D shows EP8 full here; dropping the shared bit must silence it at once
    i_ep_full_flag = 4'hf;
    gap(8);
    chk("flag_d", 8'h01, o_flag_out_d);
    i_ext_master.wr_reg(8'h01, 8'hc8);
    gap(2);
    chk("flag_d", 8'h00, o_flag_out_d);
    chk("d_oe", 8'h00, o_flag_out_d_oe);
    i_ext_master.wr_reg(8'h01, 8'hca);
    i_ext_master.wr_hidden(16'he609, 8'h1c);
    i_ext_master.rd_reg(8'h04, 8'h1c);
    i_ext_master.wr_hidden(16'he608, 8'h00);
    i_ext_master.rd_reg(8'h04, 8'h1c);
    {i_read_strobe_input, i_write_strobe_input, i_output_enable_input} = 3'h0;
    {i_packet_end_input, i_wake_pin} = 2'h0;
    i_ext_master.rmw_pol(8'h00, 8'ha0, 8'h1c);
    i_ext_master.rd_reg(8'h04, 8'hbc);
    gap(8);
    chk("oe", 8'h00, o_output_enable);
    chk("pkt", 8'h00, o_packet_end);
    {i_output_enable_input, i_packet_end_input} = 2'b11;
    gap(8);
    chk("oe", 8'h01, o_output_enable);
    chk("pkt", 8'h01, o_packet_end);
    n_rd = 0;
    n_wr = 0;
    {i_read_strobe_input, i_write_strobe_input} = 2'b11;
    gap(8);
    chk("rd_pulses", 8'h01, n_rd[7:0]);
    chk("wr_pulses", 8'h01, n_wr[7:0]);
    i_ext_master.wr_reg(8'h01, 8'hc2);
    gap(2);
    n_rd = 0;
    n_wr = 0;
    repeat (4)
    begin
      i_interface_clock_pin = 1'b1;
      gap(6);
      i_interface_clock_pin = 1'b0;
      gap(6);
    end
    chk("rd_pulses", 8'h04, n_rd[7:0]);
    chk("wr_pulses", 8'h04, n_wr[7:0]);
    i_ext_master.wr_reg(8'h01, 8'hcf);
    gap(8);
    chk("osc_stop", 8'h01, o_osc_stop);
    i_bus_activity = 1'b1;
    gap(1);
    i_bus_activity = 1'b0;
    gap(2);
    chk("osc_stop", 8'h00, o_osc_stop);
    i_ext_master.wr_reg(8'h01, 8'hcf);
    gap(8);
    chk("osc_stop", 8'h01, o_osc_stop);
    i_wake_pin = 1'b1;
    gap(8);
    chk("osc_stop", 8'h00, o_osc_stop);
    finish_test();
  end
endmodule
`default_nettype wire
